//--- ptw_pkg.sv
// shared constants and types for the target memory write path
package ptw_pkg;
    // target_status vector layout
    localparam int TSR_W = 12;
    localparam int BAR_W = 6;
    localparam int TSR_BAR_LSB = 0;
    localparam int TSR_WIDE = 7;
    localparam int TSR_BUSY = 8;
    localparam int TSR_BURST = 9;
    localparam int TSR_DONE = 10;
    localparam logic [TSR_W-1:0] TSR_RESET = 12'h000;
    // wishbone register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam int CTRL_ENABLE = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam int STAT_STATE_LSB = 16;
    localparam int COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    // control pin indices for the driver array
    localparam int PIN_DEVSEL = 0;
    localparam int PIN_TRDY = 1;
    localparam int PIN_STOP = 2;
    localparam int PIN_ACK64 = 3;
    localparam int PIN_N = 4;
    // target sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_CLAIM,
        ST_DATA,
        ST_TURN,
        ST_RELEASE,
        ST_WAITBUS
    } ptw_state_t;
endpackage : ptw_pkg

//--- ptw_stage.sv
// one-stage local-side write data pipeline
`timescale 1ns/1ps
module ptw_stage #(
    parameter int DATA_W = 64,
    parameter int BE_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // capture side
    input wire logic load_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [BE_W-1:0] be_i,
    // drain side
    input wire logic take_i,
    output logic valid_o,
    output logic [DATA_W-1:0] data_o,
    output logic [BE_W-1:0] be_o
);
    // valid flag: a load refills, a take empties
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
        end else if (load_i) begin
            valid_o <= 1'b1;
        end else if (take_i) begin
            valid_o <= 1'b0;
        end
    end

    // data and byte enables are only written on a completed bus phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_o <= '0;
            be_o <= '0;
        end else if (load_i) begin
            data_o <= data_i;
            be_o <= be_i;
        end
    end
endmodule : ptw_stage

//--- ptw_ctl_drv.sv
// registered driver for one sustained tri-state target control pin
`timescale 1ns/1ps
module ptw_ctl_drv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // next drive request
    input wire logic on_nxt_i,
    input wire logic assert_nxt_i,
    // pin side, active low level
    output logic pin_o,
    output logic pin_oe_o
);
    // pin level and enable are flops so the pin never glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b1;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o <= ~(on_nxt_i & assert_nxt_i);
            pin_oe_o <= on_nxt_i;
        end
    end
endmodule : ptw_ctl_drv

//--- ptw_target_write.sv
// target memory write path: pci control, local pipeline, status and wishbone regs
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module ptw_target_write #(
    parameter int DATA_W = 64,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pci bus inputs, same clock as the core
    input wire logic framen_i,
    input wire logic irdyn_i,
    input wire logic req64n_i,
    input wire logic [DATA_W-1:0] ad_i,
    input wire logic [DATA_W/8-1:0] cben_i,
    // address decoder result, valid in the decode cycle
    input wire logic hit_i,
    input wire logic [ptw_pkg::BAR_W-1:0] bar_hit_i,
    // pci target control pins
    output logic devseln_o,
    output logic devseln_oe_o,
    output logic trdyn_o,
    output logic trdyn_oe_o,
    output logic stopn_o,
    output logic stopn_oe_o,
    output logic ack64n_o,
    output logic ack64n_oe_o,
    // local side
    input wire logic local_ready_n_i,
    output logic local_ack_n_o,
    output logic local_xfer_n_o,
    output logic local_frame_n_o,
    output logic [DATA_W-1:0] local_data_out_o,
    output logic [DATA_W/8-1:0] local_byte_en_out_o,
    output logic [ptw_pkg::TSR_W-1:0] target_status_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam int BE_W = DATA_W / 8;
    localparam bit WIDE = (DATA_W == 64);

    ptw_pkg::ptw_state_t state_r;
    ptw_pkg::ptw_state_t state_nxt;
    logic bus_idle_r;
    logic is64_r;
    logic ready_prev_r;
    logic local_frame_r;
    logic enable_r;
    logic [ptw_pkg::TSR_W-1:0] tsr_r;
    logic [ptw_pkg::COUNT_W-1:0] count_r;
    logic pipe_valid;
    logic dphase;
    logic last_phase;
    logic xfer;
    logic burst_seen;
    logic [ptw_pkg::PIN_N-1:0] pin_on_nxt;
    logic [ptw_pkg::PIN_N-1:0] pin_asrt_nxt;
    logic [ptw_pkg::PIN_N-1:0] pin_lvl;
    logic [ptw_pkg::PIN_N-1:0] pin_oe;
    logic wb_req;
    logic [ADDR_W-1:0] wb_word;

    // control drivers are on from claim through the drive-high turn cycle
    function automatic logic drv_active(input ptw_pkg::ptw_state_t s);
        drv_active = (s == ptw_pkg::ST_CLAIM) || (s == ptw_pkg::ST_DATA) || (s == ptw_pkg::ST_TURN);
    endfunction : drv_active

    // the claim spans these states; burst detection is armed in them
    function automatic logic in_claim(input ptw_pkg::ptw_state_t s);
        in_claim = (s == ptw_pkg::ST_DECODE) || (s == ptw_pkg::ST_CLAIM) || (s == ptw_pkg::ST_DATA);
    endfunction : in_claim

    // bus events seen this cycle
    assign dphase = (state_r == ptw_pkg::ST_DATA) && !trdyn_o && !irdyn_i;
    assign last_phase = dphase && framen_i;
    assign burst_seen = in_claim(state_r) && state_nxt != ptw_pkg::ST_WAITBUS && !irdyn_i && !framen_i;
    assign xfer = !local_ack_n_o && ready_prev_r;

    // bus idle tracker so only a true address phase starts a claim
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_idle_r <= 1'b1;
        end else begin
            bus_idle_r <= framen_i && irdyn_i;
        end
    end

    // 64-bit request caught during the address phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            is64_r <= 1'b0;
        end else if (state_r == ptw_pkg::ST_IDLE && state_nxt == ptw_pkg::ST_DECODE) begin
            is64_r <= WIDE && !req64n_i;
        end
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ptw_pkg::ST_IDLE: begin
                if (!framen_i && bus_idle_r && enable_r) begin
                    state_nxt = ptw_pkg::ST_DECODE;
                end
            end
            ptw_pkg::ST_DECODE: begin
                state_nxt = hit_i ? ptw_pkg::ST_CLAIM : ptw_pkg::ST_WAITBUS;
            end
            ptw_pkg::ST_CLAIM: begin
                state_nxt = ptw_pkg::ST_DATA;
            end
            ptw_pkg::ST_DATA: begin
                if (last_phase) begin
                    state_nxt = ptw_pkg::ST_TURN;
                end
            end
            ptw_pkg::ST_TURN: begin
                state_nxt = ptw_pkg::ST_RELEASE;
            end
            ptw_pkg::ST_RELEASE: begin
                if (!pipe_valid || xfer) begin
                    state_nxt = ptw_pkg::ST_IDLE;
                end
            end
            ptw_pkg::ST_WAITBUS: begin
                if (framen_i && irdyn_i) begin
                    state_nxt = ptw_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = ptw_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ptw_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // local ready remembered for the transfer strobe; trdy uses the current local ready
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_prev_r <= 1'b0;
        end else begin
            ready_prev_r <= !local_ready_n_i;
        end
    end

    // next drive of each control pin; stop is never asserted on this path
    always_comb begin
        pin_on_nxt = '0;
        pin_asrt_nxt = '0;
        pin_on_nxt[ptw_pkg::PIN_DEVSEL] = drv_active(state_nxt);
        pin_on_nxt[ptw_pkg::PIN_TRDY] = drv_active(state_nxt);
        pin_on_nxt[ptw_pkg::PIN_STOP] = drv_active(state_nxt);
        pin_on_nxt[ptw_pkg::PIN_ACK64] = WIDE && drv_active(state_nxt);
        pin_asrt_nxt[ptw_pkg::PIN_DEVSEL] = (state_nxt == ptw_pkg::ST_DATA);
        pin_asrt_nxt[ptw_pkg::PIN_ACK64] = (state_nxt == ptw_pkg::ST_DATA) && is64_r;
        // trdy only follows a local ready, in the first phase and in bursts
        pin_asrt_nxt[ptw_pkg::PIN_TRDY] = (state_nxt == ptw_pkg::ST_DATA) && !local_ready_n_i;
    end

    // one registered driver per control pin
    genvar gi;
    generate
        for (gi = 0; gi < ptw_pkg::PIN_N; gi++) begin : g_drv
            ptw_ctl_drv u_drv (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .on_nxt_i(pin_on_nxt[gi]),
                .assert_nxt_i(pin_asrt_nxt[gi]),
                .pin_o(pin_lvl[gi]),
                .pin_oe_o(pin_oe[gi])
            );
        end
    endgenerate

    // pin map
    assign devseln_o = pin_lvl[ptw_pkg::PIN_DEVSEL];
    assign devseln_oe_o = pin_oe[ptw_pkg::PIN_DEVSEL];
    assign trdyn_o = pin_lvl[ptw_pkg::PIN_TRDY];
    assign trdyn_oe_o = pin_oe[ptw_pkg::PIN_TRDY];
    assign stopn_o = pin_lvl[ptw_pkg::PIN_STOP];
    assign stopn_oe_o = pin_oe[ptw_pkg::PIN_STOP];
    assign ack64n_o = pin_lvl[ptw_pkg::PIN_ACK64];
    assign ack64n_oe_o = pin_oe[ptw_pkg::PIN_ACK64];

    // one-stage pipeline; a phase only completes when the slot will be free
    ptw_stage #(
        .DATA_W(DATA_W),
        .BE_W(BE_W)
    ) u_stage (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(dphase),
        .data_i(ad_i),
        .be_i(cben_i),
        .take_i(xfer),
        .valid_o(pipe_valid),
        .data_o(local_data_out_o),
        .be_o(local_byte_en_out_o)
    );

    // local handshake outputs
    assign local_ack_n_o = !pipe_valid;
    assign local_xfer_n_o = !xfer;
    assign local_frame_n_o = !local_frame_r;

    // local frame from claim until the pipeline drains after release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_frame_r <= 1'b0;
        end else if (state_nxt == ptw_pkg::ST_CLAIM) begin
            local_frame_r <= 1'b1;
        end else if (state_r == ptw_pkg::ST_RELEASE && state_nxt == ptw_pkg::ST_IDLE) begin
            local_frame_r <= 1'b0;
        end
    end

    // target status vector; a clear burst bit never implies single-cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tsr_r <= ptw_pkg::TSR_RESET;
        end else if (state_r == ptw_pkg::ST_TURN) begin
            tsr_r <= ptw_pkg::TSR_RESET;
        end else begin
            if (state_nxt == ptw_pkg::ST_CLAIM) begin
                tsr_r[ptw_pkg::TSR_BAR_LSB +: ptw_pkg::BAR_W] <= bar_hit_i;
                tsr_r[ptw_pkg::TSR_WIDE] <= is64_r;
                tsr_r[ptw_pkg::TSR_BUSY] <= 1'b1;
            end
            if (burst_seen) begin
                tsr_r[ptw_pkg::TSR_BURST] <= 1'b1;
            end
            tsr_r[ptw_pkg::TSR_DONE] <= dphase;
        end
    end
    assign target_status_o = tsr_r;

    // wishbone: one-cycle registered ack, dropped the cycle after
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_word = {wb_adr_i[ADDR_W-1:2], 2'b00};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    // read mux registered with the ack; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_ack_o) begin
            wb_dat_o <= 32'h00000000;
            if (wb_word == ADDR_W'(ptw_pkg::REG_CTRL)) begin
                wb_dat_o[ptw_pkg::CTRL_ENABLE] <= enable_r;
            end else if (wb_word == ADDR_W'(ptw_pkg::REG_STATUS)) begin
                wb_dat_o[ptw_pkg::TSR_W-1:0] <= tsr_r;
                wb_dat_o[ptw_pkg::STAT_STATE_LSB +: 3] <= state_r;
            end else if (wb_word == ADDR_W'(ptw_pkg::REG_COUNT)) begin
                wb_dat_o[ptw_pkg::COUNT_W-1:0] <= count_r;
            end
        end
    end

    // control register: enable gates new claims, written at the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= ptw_pkg::CTRL_ENABLE_RST;
        end else if (wb_req && wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_word == ADDR_W'(ptw_pkg::REG_CTRL)) begin
            enable_r <= wb_dat_i[ptw_pkg::CTRL_ENABLE];
        end
    end

    // completed phase counter; a write clears it but a same-cycle phase counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= ptw_pkg::COUNT_RST;
        end else if (wb_req && wb_ack_o && wb_we_i && wb_word == ADDR_W'(ptw_pkg::REG_COUNT)) begin
            count_r <= dphase ? ptw_pkg::COUNT_W'(1) : ptw_pkg::COUNT_RST;
        end else if (dphase) begin
            count_r <= count_r + ptw_pkg::COUNT_W'(1);
        end
    end

    // checks on the documented write sequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_drive_high;
        devseln_oe_o && trdyn_oe_o && stopn_oe_o && devseln_o && trdyn_o && stopn_o;
    endsequence
    sequence s_released;
        !devseln_oe_o && !trdyn_oe_o && !stopn_oe_o && !ack64n_oe_o;
    endsequence

    a_ack_follows_phase: assert property (dphase |=> !local_ack_n_o && local_data_out_o == $past(ad_i))
        else $error("ack or data missing after a completed phase");
    a_ack_only_valid: assert property ($fell(local_ack_n_o) |-> $past(dphase))
        else $error("ack rose without a captured phase");
    a_xfer_defined: assert property (!local_xfer_n_o |-> !local_ack_n_o && $past(!local_ready_n_i))
        else $error("transfer strobe without ack and prior ready");
    a_done_bit_set: assert property (dphase |=> target_status_o[ptw_pkg::TSR_DONE])
        else $error("done status bit missing after phase");
    a_turn_release: assert property (last_phase |=> s_drive_high ##1 s_released)
        else $error("drive-high then release sequence broken");
    a_status_cleared: assert property (last_phase |=> ##1 target_status_o == ptw_pkg::TSR_RESET)
        else $error("status vector not cleared after transaction");
    a_frame_drop: assert property ($rose(local_frame_n_o) |-> $past(target_status_o == ptw_pkg::TSR_RESET)
                                   && $past(local_ack_n_o || !local_xfer_n_o))
        else $error("local frame dropped too early");
    a_master_wait: assert property (state_r == ptw_pkg::ST_DATA && irdyn_i && (local_ack_n_o || xfer)
                                    |=> local_ack_n_o && local_xfer_n_o)
        else $error("ack held through a master wait state");
    a_local_stall: assert property (local_ready_n_i |=> local_xfer_n_o && trdyn_o)
        else $error("transfer or trdy despite local wait");
    a_first_trdy: assert property ($fell(trdyn_o) |-> $past(!local_ready_n_i))
        else $error("trdy asserted without local ready");
    a_narrow_ack64: assert property (!WIDE |-> !ack64n_oe_o)
        else $error("narrow variant drives the 64-bit acknowledge");
    a_busy_bit: assert property (state_r == ptw_pkg::ST_DATA |-> target_status_o[ptw_pkg::TSR_BUSY])
        else $error("busy bit clear during data phases");
endmodule : ptw_target_write

//--- ptw_master_model.sv
// pci bus master model: address phase, then data phases with random wait states
`timescale 1ns/1ps
module ptw_master_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command from the bench
    input wire logic go_i,
    input wire logic wide_i,
    input wire logic wait_i,
    input wire logic [7:0] n_i,
    input wire logic [63:0] base_i,
    // target answer
    input wire logic trdyn_i,
    input wire logic trdyn_oe_i,
    // bus drive
    output logic framen_o,
    output logic irdyn_o,
    output logic req64n_o,
    output logic [63:0] ad_o,
    output logic [7:0] cben_o,
    output logic busy_o
);
    logic phase_w;
    logic hold_w;
    logic [3:0] waits_r;
    logic [7:0] k_r;
    logic [7:0] k_nxt;
    // a phase completes at an edge where both ready strobes are low
    assign phase_w = busy_o && !irdyn_o && !trdyn_i && trdyn_oe_i;
    assign k_nxt = phase_w ? k_r + 8'h01 : k_r;
    // a wait is only honoured while fewer than eight idle clocks have passed in a row
    assign hold_w = wait_i && waits_r != 4'h8;
    // bus sequencer; released strobes go high as with pull-ups, ad flips
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            framen_o <= 1'b1;
            irdyn_o <= 1'b1;
            req64n_o <= 1'b1;
            ad_o <= 64'h0;
            cben_o <= 8'hFF;
            k_r <= 8'h00;
            waits_r <= 4'h0;
            busy_o <= 1'b0;
        end else if (!busy_o) begin
            if (go_i) begin
                framen_o <= 1'b0;
                req64n_o <= !wide_i;
                ad_o <= base_i;
                cben_o <= 8'h07; // memory write command
                k_r <= 8'h00;
                busy_o <= 1'b1;
            end
        end else if (phase_w && k_r == n_i - 8'h01) begin
            framen_o <= 1'b1;
            irdyn_o <= 1'b1;
            req64n_o <= 1'b1;
            ad_o <= ~ad_o;
            cben_o <= ~cben_o;
            busy_o <= 1'b0;
        end else if (irdyn_o || phase_w) begin
            irdyn_o <= hold_w;
            framen_o <= !hold_w && k_nxt == n_i - 8'h01; // frame ends with the last ready phase
            waits_r <= hold_w ? waits_r + 4'h1 : 4'h0;
            ad_o <= base_i + {56'h0, k_nxt};
            cben_o <= ~k_nxt;
            k_r <= k_nxt;
        end
    end
endmodule : ptw_master_model

//--- testbench.sv
// self-checking bench: master model, random local side and wishbone accesses
`timescale 1ns/1ps
module testbench;
    logic clk_i, rst_i, go, wide, wait_r, zero, hit, local_ready_n;
    logic [7:0] n_r;
    logic [5:0] bar;
    logic [63:0] base, ad, local_data;
    logic framen, irdyn, req64n, busy;
    logic [7:0] cben, local_be;
    logic devseln, devseln_oe, trdyn, trdyn_oe, stopn, stopn_oe, ack64n, ack64n_oe;
    logic local_ack_n, local_xfer_n, local_frame_n;
    logic [ptw_pkg::TSR_W-1:0] tsr;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [31:0] seed = 32'hA71DB9AA;
    int n_mismatch = 0;
    int total_checks = 0;
    int rx, cyc, first_x, last_x, phases;
    logic [63:0] exp_d[$];
    logic prev_rdy, prev_phase, prev_oe, prev_xfer, prev_ackn, prev_fall, prev_busy, seen_both, saw_burst;
    logic [3:0] prev_pins;

    ptw_target_write dut (
        .clk_i(clk_i), .rst_i(rst_i), .framen_i(framen), .irdyn_i(irdyn), .req64n_i(req64n),
        .ad_i(ad), .cben_i(cben), .hit_i(hit), .bar_hit_i(bar),
        .devseln_o(devseln), .devseln_oe_o(devseln_oe), .trdyn_o(trdyn), .trdyn_oe_o(trdyn_oe),
        .stopn_o(stopn), .stopn_oe_o(stopn_oe), .ack64n_o(ack64n), .ack64n_oe_o(ack64n_oe),
        .local_ready_n_i(local_ready_n), .local_ack_n_o(local_ack_n), .local_xfer_n_o(local_xfer_n),
        .local_frame_n_o(local_frame_n), .local_data_out_o(local_data), .local_byte_en_out_o(local_be),
        .target_status_o(tsr), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack)
    );

    ptw_master_model master (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .wide_i(wide), .wait_i(wait_r), .n_i(n_r),
        .base_i(base), .trdyn_i(trdyn), .trdyn_oe_i(trdyn_oe), .framen_o(framen), .irdyn_o(irdyn),
        .req64n_o(req64n), .ad_o(ad), .cben_o(cben), .busy_o(busy)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // classic wishbone single cycle; waits for ack, then releases
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= 4'hF;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack !== 1'b1 && t < 20);
        q = wb_dat_r;
        check(wb_ack, 1'b1, "wb ack");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    // one write transaction of n phases, then end-of-transfer checks
    task automatic run(input logic [7:0] n, input logic w, input logic zw);
        int t;
        logic [63:0] b;
        t = 0;
        zero <= zw;
        repeat (3) @(posedge clk_i);
        b = {seed, ~seed};
        exp_d.delete();
        for (int k = 0; k < n; k++) exp_d.push_back(b + k);
        rx = 0;
        seen_both = 1'b0;
        saw_burst = 1'b0;
        base <= b;
        n_r <= n;
        wide <= w;
        bar <= seed[11:6];
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
        while ((busy || local_frame_n !== 1'b1) && t < 400) begin
            @(posedge clk_i);
            t++;
        end
        check(t < 400, 1'b1, "run end");
        @(posedge clk_i);
        check(rx, n, "transfers");
        check(saw_burst, seen_both, "burst bit");
        if (zw) check(last_x - first_x, n - 8'h01, "burst rate");
        phases += n;
    endtask : run

    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // random local readiness and master waits, none in zero-wait runs
    always @(posedge clk_i) begin
        seed = lfsr(seed);
        local_ready_n <= !zero && seed[5:4] == 2'b00;
        wait_r <= !zero && seed[3:2] == 2'b00;
    end

    // cycle monitor, sampled mid-cycle where everything has settled
    always @(negedge clk_i) begin
        cyc++;
        if (rst_i) begin
            prev_rdy = 1'b1;
            prev_phase = 1'b0;
            prev_oe = 1'b0;
            prev_xfer = 1'b1;
            prev_busy = 1'b0;
            prev_fall = 1'b0;
        end else begin
            if (local_xfer_n === 1'b0) begin
                check(local_data, exp_d[rx], "local data");
                check(local_be, {56'h0, ~rx[7:0]}, "byte enables");
                if (rx == 0) first_x = cyc;
                last_x = cyc;
                rx++;
            end
            check(local_xfer_n, !(local_ack_n === 1'b0 && prev_rdy === 1'b0), "xfer strobe");
            if (prev_rdy === 1'b1 && trdyn_oe === 1'b1) check(trdyn, 1, "trdy hold");
            check(tsr[ptw_pkg::TSR_DONE], prev_phase, "phase done bit");
            if (prev_phase) check(local_ack_n, 0, "ack after phase");
            else if (prev_xfer === 1'b0) check(local_ack_n, 1, "ack empty pipe");
            if (prev_oe && trdyn_oe !== 1'b1) begin
                check(prev_pins, 4'hF, "drive high cycle");
                check({devseln_oe, stopn_oe, ack64n_oe}, 0, "pins released");
                check(tsr, 0, "status clear");
            end
            if (prev_fall && prev_ackn === 1'b1) check(local_frame_n, 1, "frame end");
            if (tsr[ptw_pkg::TSR_BUSY] === 1'b1) check(local_frame_n, 0, "frame held");
            if (devseln_oe === 1'b1 && devseln === 1'b0) check(tsr[ptw_pkg::TSR_BUSY], 1, "busy bit");
            if (devseln_oe === 1'b1) check({ack64n, stopn}, {devseln | !wide, 1'b1}, "ack64 and stop");
            if (!prev_busy && tsr[ptw_pkg::TSR_BUSY] === 1'b1) begin
                check(tsr[ptw_pkg::TSR_WIDE], wide, "wide bit");
                check(tsr[5:0], bar, "bar bits");
            end
            if (busy && !irdyn && !framen) seen_both = 1'b1;
            if (tsr[ptw_pkg::TSR_BURST] === 1'b1) saw_burst = 1'b1;
            prev_fall = prev_oe && trdyn_oe !== 1'b1;
            prev_rdy = local_ready_n;
            prev_phase = !irdyn && trdyn === 1'b0 && trdyn_oe === 1'b1;
            prev_oe = trdyn_oe === 1'b1;
            prev_xfer = local_xfer_n;
            prev_ackn = local_ack_n;
            prev_busy = tsr[ptw_pkg::TSR_BUSY] === 1'b1;
            prev_pins = {devseln, trdyn, stopn, ack64n};
        end
    end

    // watchdog
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    // main sequence
    initial begin
        {rst_i, hit} = 2'b11;
        {go, wide, zero, wait_r, local_ready_n} = 5'b00001;
        {wb_cyc, wb_stb, wb_we} = 3'b000;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        bar = 6'h00;
        base = 64'h0;
        n_r = 8'h01;
        phases = 0;
        cyc = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ptw_pkg::REG_CTRL, 32'h0);
        check(q, 1, "ctrl reset");
        wb(1'b0, ptw_pkg::REG_COUNT, 32'h0);
        check(q, 0, "count reset");
        wb(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb(1'b0, 8'h0C, 32'h0);
        check(q, 0, "unmapped read");
        wb(1'b1, ptw_pkg::REG_CTRL, 32'h0);
        wb(1'b0, ptw_pkg::REG_CTRL, 32'h0);
        check(q, 0, "ctrl written");
        wb(1'b1, ptw_pkg::REG_CTRL, 32'h1);
        wb(1'b0, ptw_pkg::REG_CTRL, 32'h0);
        check(q, 1, "ctrl restored");
        run(8'h01, 1'b1, 1'b1);
        run(8'h05, 1'b1, 1'b1);
        run(8'h05, 1'b0, 1'b0);
        for (int i = 0; i < 14; i++) run({5'h00, seed[2:0]} + 8'h01, seed[3], 1'b0);
        wb(1'b0, ptw_pkg::REG_COUNT, 32'h0);
        check(q, phases, "phase count");
        wb(1'b1, ptw_pkg::REG_COUNT, 32'h0);
        wb(1'b0, ptw_pkg::REG_COUNT, 32'h0);
        check(q, 0, "count cleared");
        wb(1'b0, ptw_pkg::REG_STATUS, 32'h0);
        check(q, 0, "idle status");
        stop_test();
    end
endmodule : testbench
